// ### rtl/bio_params.svh
// Constants for the board user I/O block with tri-color LED dimming.
// Function
// - Push buttons read low while released and high only while pressed.
// - Slide switches are steady levels, not events.
// - Drive an individual LED high to light it, low to darken it.
// - Drive a tri-color channel high to light that element, low to darken it.
// - Every color channel of both tri-color LEDs is controlled independently.
// - Tri-color channels are pulse-width modulated, never above half duty.
// - Each color channel has its own duty setting from 0% to 50%.
`ifndef BIO_PARAMS_SVH
`define BIO_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define BIO_OFS_LED      8'h00
`define BIO_OFS_INPUT    8'h04
`define BIO_OFS_RGB0     8'h08
`define BIO_OFS_RGB1     8'h0c
`define BIO_OFS_CTRL     8'h10

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define BIO_NUM_BTN      4
`define BIO_NUM_SW       2
`define BIO_NUM_LED      4
`define BIO_NUM_RGB      2
`define BIO_IN_SW_POS    4
`define BIO_CTRL_EN_POS  0
`define BIO_PWM_W        8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BIO_RST_LED      4'h0
`define BIO_RST_DUTY     24'h000000
`define BIO_RST_EN       1'b1

// ----------------------------------------------------------------------------
// Timing and limits
// ----------------------------------------------------------------------------
// Half of the 256-step period: the brightest allowed setting.
`define BIO_DUTY_MAX     8'h80
`define BIO_PWM_LAST     8'hff
`define BIO_DIV_DEFAULT  4
`define BIO_RESP_OKAY    2'b00
`define BIO_RESP_SLVERR  2'b10

`endif

// ### rtl/bio_pkg.sv
// Types shared by the board user I/O block.
package bio_pkg;

   // One tri-color LED: duty settings of its three elements.
   typedef struct packed {
      logic [7:0] blue;
      logic [7:0] green;
      logic [7:0] red;
   } bio_rgb_t;

   typedef enum logic [2:0] {
      BIO_REG_LED,
      BIO_REG_INPUT,
      BIO_REG_RGB0,
      BIO_REG_RGB1,
      BIO_REG_CTRL,
      BIO_REG_NONE
   } bio_reg_t;

endpackage : bio_pkg

// ### rtl/bio_pwm.sv
// One pulse-width modulated color channel driven from a shared period counter.
`timescale 1ns/100ps
`include "bio_params.svh"

module bio_pwm
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  tick,
   input  wire logic [`BIO_PWM_W-1:0] count,
   input  wire logic                  enable,
   input  wire logic [7:0]            duty_in,
   output logic                       pwm_out
);

   logic [`BIO_PWM_W-1:0] active_duty;

   // Loading only at the wrap keeps every period whole, so no glitch pulse
   // appears when software changes the setting mid-period.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         active_duty <= `BIO_PWM_W'(`BIO_RST_DUTY);
      else if (tick && count == `BIO_PWM_LAST)
         active_duty <= duty_in;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pwm_out <= 1'b0;
      else
         pwm_out <= enable && (count < active_duty);
   end

endmodule : bio_pwm

// ### rtl/bio_top.sv
// Board user I/O: buttons, switches, LEDs and dimmed tri-color LEDs on AXI4-Lite.
`timescale 1ns/100ps
`include "bio_params.svh"

module bio_top
#(
   parameter int unsigned PWM_DIV = `BIO_DIV_DEFAULT
)
(
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic [`BIO_NUM_BTN-1:0]  btn_in,
   input  wire logic [`BIO_NUM_SW-1:0]   sw_in,
   output logic [`BIO_NUM_LED-1:0]       led_out,
   output logic [`BIO_NUM_RGB*3-1:0]     rgb_out
);

   // ------------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------------
   generate
      if (PWM_DIV < 1 || PWM_DIV > 65535)
      begin : g_bad_div
         $error("PWM_DIV must lie between 1 and 65535");
      end
   endgenerate

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   function automatic bio_pkg::bio_reg_t decode(input logic [7:0] addr);
      bio_pkg::bio_reg_t r;
      r = bio_pkg::BIO_REG_NONE;
      if (addr[1:0] == 2'h0)
      begin
         unique case (addr)
            `BIO_OFS_LED:   r = bio_pkg::BIO_REG_LED;
            `BIO_OFS_INPUT: r = bio_pkg::BIO_REG_INPUT;
            `BIO_OFS_RGB0:  r = bio_pkg::BIO_REG_RGB0;
            `BIO_OFS_RGB1:  r = bio_pkg::BIO_REG_RGB1;
            `BIO_OFS_CTRL:  r = bio_pkg::BIO_REG_CTRL;
            default:        r = bio_pkg::BIO_REG_NONE;
         endcase
      end
      return r;
   endfunction : decode

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] m;
      m = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            m[i*8 +: 8] = new_v[i*8 +: 8];
      return m;
   endfunction : merge

   // Settings above half duty are held at half, so software cannot overdrive.
   function automatic logic [7:0] clamp(input logic [7:0] d);
      return (d > `BIO_DUTY_MAX) ? `BIO_DUTY_MAX : d;
   endfunction : clamp

   function automatic bio_pkg::bio_rgb_t clamp_rgb(input logic [23:0] v);
      bio_pkg::bio_rgb_t c;
      c.red   = clamp(v[7:0]);
      c.green = clamp(v[15:8]);
      c.blue  = clamp(v[23:16]);
      return c;
   endfunction : clamp_rgb

   // ------------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------------
   localparam int NIN = `BIO_NUM_BTN + `BIO_NUM_SW;

   logic [NIN-1:0] in_meta;
   logic [NIN-1:0] in_sync;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_meta <= '0;
         in_sync <= '0;
      end
      else
      begin
         in_meta <= {sw_in, btn_in};
         in_sync <= in_meta;
      end
   end

   // ------------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------------
   logic [`BIO_NUM_LED-1:0] led_reg;
   bio_pkg::bio_rgb_t       duty [`BIO_NUM_RGB];
   logic                    pwm_en;

   logic                    aw_held;
   logic                    w_held;
   logic [7:0]              aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    do_write;
   bio_pkg::bio_reg_t       wr_reg;
   logic [31:0]             led_wr;
   logic [31:0]             rgb0_wr;
   logic [31:0]             rgb1_wr;

   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_reg   = decode(aw_addr);

   // The byte-merged words are formed here so that each field can be sliced.
   assign led_wr   = merge(32'(led_reg), w_data, w_strb);
   assign rgb0_wr  = merge(32'(duty[0]), w_data, w_strb);
   assign rgb1_wr  = merge(32'(duty[1]), w_data, w_strb);

   // ------------------------------------------------------------------------
   // Write channels
   // ------------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held       <= 1'b0;
         aw_addr       <= 8'h00;
         s_axi_awready <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         aw_held       <= 1'b0;
         s_axi_awready <= 1'b1;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held       <= 1'b1;
         aw_addr       <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else if (!aw_held)
         s_axi_awready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held       <= 1'b0;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_wready <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         w_held       <= 1'b0;
         s_axi_wready <= 1'b1;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held       <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      else if (!w_held)
         s_axi_wready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `BIO_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_reg == bio_pkg::BIO_REG_NONE) ? `BIO_RESP_SLVERR
                                                           : `BIO_RESP_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ------------------------------------------------------------------------
   // Register updates
   // ------------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         led_reg <= `BIO_RST_LED;
         pwm_en  <= `BIO_RST_EN;
         for (int i = 0; i < `BIO_NUM_RGB; i++)
            duty[i] <= `BIO_RST_DUTY;
      end
      else if (do_write)
      begin
         unique case (wr_reg)
            bio_pkg::BIO_REG_LED:
               led_reg <= led_wr[`BIO_NUM_LED-1:0];
            bio_pkg::BIO_REG_RGB0:
               duty[0] <= clamp_rgb(rgb0_wr[23:0]);
            bio_pkg::BIO_REG_RGB1:
               duty[1] <= clamp_rgb(rgb1_wr[23:0]);
            bio_pkg::BIO_REG_CTRL:
               if (w_strb[0])
                  pwm_en <= w_data[`BIO_CTRL_EN_POS];
            default:
               led_reg <= led_reg;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `BIO_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `BIO_RESP_OKAY;
         s_axi_rdata   <= 32'h00000000;
         unique case (decode(s_axi_araddr))
            bio_pkg::BIO_REG_LED:   s_axi_rdata <= 32'(led_reg);
            bio_pkg::BIO_REG_INPUT: s_axi_rdata <= 32'(in_sync);
            bio_pkg::BIO_REG_RGB0:  s_axi_rdata <= 32'(duty[0]);
            bio_pkg::BIO_REG_RGB1:  s_axi_rdata <= 32'(duty[1]);
            bio_pkg::BIO_REG_CTRL:  s_axi_rdata <= 32'(pwm_en);
            default:                s_axi_rresp <= `BIO_RESP_SLVERR;
         endcase
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
         begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
      else
         s_axi_arready <= 1'b1;
   end

   // ------------------------------------------------------------------------
   // LED outputs
   // ------------------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         led_out <= `BIO_RST_LED;
      else
         led_out <= led_reg;
   end

   // ------------------------------------------------------------------------
   // Period counter
   // ------------------------------------------------------------------------
   logic [15:0]           div_cnt;
   logic                  tick;
   logic [`BIO_PWM_W-1:0] pcnt;

   assign tick = (div_cnt == 16'(PWM_DIV - 1));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_cnt <= 16'h0000;
      else if (tick)
         div_cnt <= 16'h0000;
      else
         div_cnt <= div_cnt + 16'h0001;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pcnt <= `BIO_PWM_W'(8'h00);
      else if (tick)
         pcnt <= pcnt + `BIO_PWM_W'(8'h01);
   end

   // ------------------------------------------------------------------------
   // Color channels, red green blue per tri-color LED
   // ------------------------------------------------------------------------
   generate
      for (genvar k = 0; k < `BIO_NUM_RGB * 3; k++)
      begin : g_ch
         bio_pwm u_pwm
         (
            .aclk    (aclk),
            .aresetn (aresetn),
            .tick    (tick),
            .count   (pcnt),
            .enable  (pwm_en),
            .duty_in (duty[k / 3][(k % 3) * 8 +: 8]),
            .pwm_out (rgb_out[k])
         );
      end
   endgenerate

endmodule : bio_top

// ### test/bio_board.sv
// Model of the board's push buttons and slide switches.
`timescale 1ns/100ps
`include "bio_params.svh"

module bio_board
(
   input  wire logic [`BIO_NUM_BTN-1:0] press,
   input  wire logic [`BIO_NUM_SW-1:0]  slide,
   output logic [`BIO_NUM_BTN-1:0]      btn_in,
   output logic [`BIO_NUM_SW-1:0]       sw_in
);
   // A button rests low and reads high only while held down.
   assign btn_in = press;
   assign sw_in  = slide;
endmodule : bio_board

// ### test/bio_top_props.sv
// Concurrent checks on the ports of the board user I/O block.
`timescale 1ns/100ps
`include "bio_params.svh"

module bio_top_props
#(
   parameter int unsigned PWM_DIV = 4
)
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [3:0]  btn_in,
   input wire logic [1:0]  sw_in,
   input wire logic [3:0]  led_out,
   input wire logic [5:0]  rgb_out
);
   localparam int unsigned LIT_MAX = 128 * PWM_DIV;
   logic [23:0] lit_run;
   wire         aw_t = s_axi_awvalid && s_axi_awready;
   wire         w_t  = s_axi_wvalid && s_axi_wready;
   wire         ar_t = s_axi_arvalid && s_axi_arready;

   // Every channel with a nonzero duty lights at the period start, so one run covers the widest pulse.
   always_ff @(posedge aclk)
      if (!aresetn || rgb_out == 6'h00)
         lit_run <= 24'h000000;
      else
         lit_run <= lit_run + 24'h000001;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_both_taken;
      aw_t && w_t;
   endsequence
   sequence s_inputs_read;
      $stable({sw_in, btn_in})[*5] ##0 (ar_t && s_axi_araddr == 8'h04);
   endsequence

   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_w_answer: assert property (s_both_taken |=>
      (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid) else $error("no write answer");
   a_ready_back: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not reopened");
   a_r_answer: assert property (ar_t |=> s_axi_rvalid && !s_axi_arready)
      else $error("no read answer");
   a_bad_addr: assert property (ar_t && (s_axi_araddr > 8'h10 || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("bad address read ok");
   a_inputs_read: assert property (s_inputs_read |=>
      s_axi_rdata[5:0] == $past({sw_in, btn_in})) else $error("inputs misread");
   a_led_follow: assert property (s_both_taken ##0 (s_axi_awaddr == 8'h00 &&
      s_axi_wstrb[0]) |-> ##3 led_out == $past(s_axi_wdata[3:0], 3)) else $error("led wrong");
   a_half_duty: assert property (lit_run <= LIT_MAX)
      else $error("pulse over half period");
   a_lit_together: assert property (rgb_out != 6'h00 && $past(rgb_out) != 6'h00 |->
      (rgb_out & ~$past(rgb_out)) == 6'h00) else $error("channel lit mid pulse");
endmodule : bio_top_props

bind bio_top bio_top_props #(.PWM_DIV(PWM_DIV)) u_props (.*);

// ### test/tb.sv
// Self-checking bench for the board user I/O block.
`timescale 1ns/100ps
`include "bio_params.svh"

module tb;
   localparam int unsigned DIV = 1;
   typedef struct {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] rexp;
      logic [1:0]  resp;
   } bio_row_t;
   bio_row_t    rows [8] = '{
      '{8'h00, 32'h0000000a, 32'h0000000a, 2'h0},
      '{8'h08, 32'h00402010, 32'h00402010, 2'h0},
      '{8'h08, 32'h00ff9081, 32'h00808080, 2'h0},
      '{8'h0c, 32'hffffff80, 32'h00808080, 2'h0},
      '{8'h10, 32'h00000001, 32'h00000001, 2'h0},
      '{8'h04, 32'h0000003f, 32'h00000000, 2'h0},
      '{8'h14, 32'h12345678, 32'h00000000, 2'h2},
      '{8'h0e, 32'h00000001, 32'h00000000, 2'h2}};
   logic [31:0] want [6] = '{32'h10, 32'h20, 32'h40, 32'h80, 32'h0, 32'h1};
   logic        aclk, aresetn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb, btn_in, led_out, press;
   logic [1:0]  s_axi_bresp, s_axi_rresp, sw_in, slide, r;
   logic [5:0]  rgb_out;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          n_errors = 0;
   int          n_checks = 0;
   logic [31:0] on [6];

   bio_top #(.PWM_DIV(DIV)) u_dut (.*);
   bio_board u_board (.press(press), .slide(slide), .btn_in(btn_in), .sw_in(sw_in));

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // --------------------------------------------------------------------
   // Bus and check tasks
   // --------------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp_v);
      n_checks++;
      if (seen !== exp_v)
      begin
         n_errors++;
         $display("Error %0t: got %h want %h", $time, seen, exp_v);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (n_errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic hang();
      n_errors++;
      $display("Error %0t: no answer", $time);
      tally_and_finish();
   endtask : hang

   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int t;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (t = 0; t < 50; t++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (t == 50) hang();
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int t;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (t = 0; t < 50; t++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (t == 50) hang();
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic reset_check();
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      chk(32'(led_out), 32'h0);
      chk(32'(rgb_out), 32'h0);
      rd(8'h10, d, r);
      chk(d, 32'h1);
      rd(8'h08, d, r);
      chk(d, 32'h0);
      rd(8'h00, d, r);
      chk(d, 32'h0);
   endtask : reset_check

   // Counts lit cycles per channel over one period from a period start.
   task automatic measure();
      int t;
      logic [5:0] prev;
      prev = 6'h3f;
      on = '{default: 32'h0};
      for (t = 0; t < 600; t++)
      begin
         @(posedge aclk);
         #1;
         if (prev == 6'h00 && rgb_out != 6'h00) break;
         prev = rgb_out;
      end
      if (t == 600) hang();
      for (t = 0; t < 256 * DIV; t++)
      begin
         foreach (on[k]) on[k] += 32'(rgb_out[k] === 1'b1);
         @(posedge aclk);
         #1;
      end
   endtask : measure

   initial
   begin
      aresetn       = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid  = 1'b0;
      s_axi_bready  = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready  = 1'b0;
      s_axi_awaddr  = 8'h00;
      s_axi_araddr  = 8'h00;
      s_axi_wdata   = 32'h0;
      s_axi_wstrb   = 4'hf;
      press         = 4'h0;
      slide         = 2'h0;
      reset_check();
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata, r);
         chk(32'(r), 32'(rows[i].resp));
         rd(rows[i].addr, d, r);
         chk(d, rows[i].rexp);
         chk(32'(r), 32'(rows[i].resp));
      end
      chk(32'(led_out), 32'ha);
      press <= 4'h9;
      slide <= 2'h2;
      repeat (4) @(posedge aclk);
      rd(8'h04, d, r);
      chk(d, 32'h29);
      press <= 4'h0;
      repeat (4) @(posedge aclk);
      rd(8'h04, d, r);
      chk(d, 32'h20);
      wr(8'h08, 32'h00402010, r);
      wr(8'h0c, 32'h00010080, r);
      measure();
      foreach (on[k]) chk(on[k], want[k] * DIV);
      wr(8'h10, 32'h0, r);
      repeat (2) @(posedge aclk);
      for (int t = 0; t < 256 * DIV; t++)
      begin
         @(posedge aclk);
         #1;
         chk(32'(rgb_out), 32'h0);
      end
      wr(8'h00, 32'h5, r);
      repeat (2) @(posedge aclk);
      #1;
      chk(32'(led_out), 32'h5);
      reset_check();
      tally_and_finish();
   end
endmodule : tb
